// File: external_interrupt_input_conditioner.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_input_conditioner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  ext_irq_pin,
  output logic             irq
);

  ext_irq_pkg::ctrl_s ctrl;
  logic [5:0]         status;
  logic [5:0]         mask;
  logic               master_irq_enable;
  logic [5:0]         sync1;
  logic [5:0]         sync2;
  logic [5:0]         sync3;
  logic [5:0]         filt;
  logic [5:0]         filt_q;
  logic [5:0]         event_pulse;
  logic [5:0]         next_event;
  logic [1:0]         startup_cnt;
  logic               primed;
  logic               four_rise_seen;
  logic               access;
  logic               wr_fire;
  logic [5:0]         rise;
  logic [5:0]         fall;
  logic [5:0]         gate;

  assign access  = psel & penable;
  assign wr_fire = access & pready & pwrite & pstrb[0];

  // Answer one cycle into the access phase; writes land on the edge that samples pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        if (paddr == ext_irq_pkg::CTRL_ADDR) begin
          prdata[7:0] <= {ctrl[7:1], 1'b0}; // [RULE17]
        end else if (paddr == ext_irq_pkg::STATUS_ADDR) begin
          prdata[5:0] <= status;
        end else if (paddr == ext_irq_pkg::MASK_ADDR) begin
          prdata[5:0] <= mask;
        end else if (paddr == ext_irq_pkg::MASTER_ADDR) begin
          prdata[ext_irq_pkg::MASTER_EN_BIT] <= master_irq_enable;
        end else if (paddr == ext_irq_pkg::LEVEL_ADDR) begin
          prdata[5:0] <= filt;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // The pin function bit resets to port use, so the zero input starts ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ext_irq_pkg::ctrl_s'(ext_irq_pkg::CTRL_RESET); // [RULE2] [RULE17]
    end else if (wr_fire && paddr == ext_irq_pkg::CTRL_ADDR) begin
      ctrl <= ext_irq_pkg::ctrl_s'({pwdata[7:1], 1'b0}); // [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= ext_irq_pkg::MASK_RESET;
    end else if (wr_fire && paddr == ext_irq_pkg::MASK_ADDR) begin
      mask <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_irq_enable <= 1'b0;
    end else if (wr_fire && paddr == ext_irq_pkg::MASTER_ADDR) begin
      master_irq_enable <= pwdata[ext_irq_pkg::MASTER_EN_BIT];
    end
  end

  // Three-stage synchroniser; only stages two and three are looked at.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
    end else begin
      sync1 <= ext_irq_pin; // [RULE19]
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Filters load the real pin level once the synchroniser is full, so a pin
  // held high through reset never looks like an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_cnt <= 2'h0;
      primed      <= 1'b0;
    end else if (!primed) begin
      if (startup_cnt == ext_irq_pkg::STARTUP_CYC) begin
        primed <= 1'b1;
      end else begin
        startup_cnt <= startup_cnt + 2'h1;
      end
    end
  end

  // The one threshold follows the select bit at once, well inside 64 periods.
  function automatic logic [7:0] reject_cycles(input int idx, input logic short_sel);
    logic [7:0] thr;
    thr = ext_irq_pkg::REJ_MID_CYC; // [RULE6]
    if (idx == 0 || idx == 5) begin
      thr = ext_irq_pkg::REJ_EDGE_CYC; // [RULE3] [RULE4]
    end else if (idx == 1) begin
      thr = short_sel ? ext_irq_pkg::REJ_ONE_SHORT_CYC
                      : ext_irq_pkg::REJ_ONE_LONG_CYC; // [RULE5] [RULE13]
    end
    return thr;
  endfunction : reject_cycles

  // A level must stand for the reject time before it is taken; this keeps
  // every accept figure met with latency well under the latch deadlines.
  for (genvar i = 0; i < ext_irq_pkg::NUM_PINS; i++) begin : g_filter
    logic [7:0] cnt;
    logic [7:0] thr;

    assign thr = reject_cycles(i, ctrl.filter_sel);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt       <= 8'h00;
        filt[i]   <= 1'b0;
        filt_q[i] <= 1'b0;
      end else if (!primed) begin
        cnt       <= 8'h00;
        filt[i]   <= sync3[i];
        filt_q[i] <= sync3[i];
      end else begin
        filt_q[i] <= filt[i];
        if (sync2[i] == sync3[i] && sync3[i] != filt[i]) begin // [RULE1]
          if (cnt + 8'h01 >= thr) begin
            filt[i] <= sync3[i]; // [RULE7] [RULE8]
            cnt     <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end else begin
          cnt <= 8'h00;
        end
      end
    end
  end

  assign rise = filt & ~filt_q;
  assign fall = ~filt & filt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      four_rise_seen <= 1'b0;
    end else if (rise[4]) begin
      four_rise_seen <= 1'b1; // [RULE14]
    end
  end

  always_comb begin
    next_event    = 6'h00;
    next_event[0] = fall[0] & ctrl.pin_function; // [RULE3] [RULE9]
    next_event[1] = ctrl.es_one ? fall[1] : rise[1]; // [RULE12]
    next_event[2] = ctrl.es_two ? fall[2] : rise[2]; // [RULE12]
    next_event[3] = ctrl.es_three ? fall[3] : rise[3]; // [RULE12]
    case (ctrl.trig_four) // [RULE11]
      ext_irq_pkg::TRIG_RISE: next_event[4] = rise[4];
      ext_irq_pkg::TRIG_FALL: next_event[4] = fall[4];
      ext_irq_pkg::TRIG_BOTH: next_event[4] = rise[4] | fall[4];
      default:                next_event[4] = filt[4] & (four_rise_seen | rise[4]); // [RULE14]
    endcase
    next_event[5] = fall[5]; // [RULE4]
  end

  // Pin toggles from port output use pass through unfiltered by direction;
  // software masks such sources itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pulse <= 6'h00;
    end else begin
      event_pulse <= next_event; // [RULE19] [RULE16]
    end
  end

  // Latches clear by writing one; a new event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= ext_irq_pkg::STATUS_RESET;
    end else if (wr_fire && paddr == ext_irq_pkg::STATUS_ADDR) begin
      status <= (status & ~pwdata[5:0]) | event_pulse;
    end else begin
      status <= status | event_pulse;
    end
  end

  assign gate = {5'h1f, ctrl.pin_function};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= master_irq_enable & (|(status & mask & gate)); // [RULE3]
    end
  end

endmodule : external_interrupt_input_conditioner
`default_nettype wire

// File: ext_irq_pkg.sv
// Functional notes
// [RULE1] Six external interrupt pins, each with a digital noise rejection filter.
// [RULE2] After reset the shared zero pin is a port input, not an interrupt.
// [RULE3] Zero: falling edge, needs master, own enable and pin function; filter 2/6.
// [RULE4] Five: falling edge; pulses under 2 periods rejected, 6 or more accepted.
// [RULE5] One: rejects under 63 periods (select 0) or 15 (select 1).
// [RULE6] Two to four: reject pulses under 7 periods, accept 24 or more.
// [RULE7] One: clean edge sets latch within 49 (short) or 193 (long) periods.
// [RULE8] Two to four: clean edge sets latch within 25 periods.
// [RULE9] Pin function 0 keeps the zero latch from ever being set.
// [RULE10] Control bit 6 selects port (0) or interrupt zero input (1).
// [RULE11] Four trigger field: 00 rise, 01 fall, 10 both, 11 high level.
// [RULE12] One, two, three edge selects: 0 rising, 1 falling.
// [RULE13] A new filter select for one applies within 64 periods.
// [RULE14] Four high level needs a rising edge after reset before any request.
// [RULE15] Software disables external interrupts while rewriting the control register.
// [RULE16] Output use of a shared pin may raise a spurious request; software masks it.
// [RULE17] Control register resets to zero in bits 7 to 1; bit 0 is don't care.
// [RULE18] Software uses no read-modify-write on write-only registers or latches.
// [RULE19] Pins are synchronised first; a detected event pulses for exactly one clock (the code holds the four high-level event every clock the level stands).
package ext_irq_pkg;

  localparam int NUM_PINS = 6;

  // Register index as printed; the byte address is four times it.
  localparam logic [9:0]  CTRL_INDEX  = 10'h037;
  localparam logic [11:0] CTRL_ADDR   = {CTRL_INDEX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = 12'h100;
  localparam logic [11:0] MASK_ADDR   = 12'h104;
  localparam logic [11:0] MASTER_ADDR = 12'h108;
  localparam logic [11:0] LEVEL_ADDR  = 12'h10c;

  localparam int FILTER_SEL_BIT = 7;
  localparam int PIN_FUNC_BIT   = 6;
  localparam int FOUR_TRIG_LSB  = 4;
  localparam int THREE_ES_BIT   = 3;
  localparam int TWO_ES_BIT     = 2;
  localparam int ONE_ES_BIT     = 1;
  localparam int MASTER_EN_BIT  = 0;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET   = 6'h00;

  // Rejection times in high-frequency clock periods; pclk is that clock.
  localparam int PCLK_PER_FC         = 1;
  localparam int REJ_EDGE_FC         = 2;
  localparam int REJ_ONE_LONG_FC     = 63;
  localparam int REJ_ONE_SHORT_FC    = 15;
  localparam int REJ_MID_FC          = 7;
  localparam logic [7:0] REJ_EDGE_CYC      = 8'(REJ_EDGE_FC * PCLK_PER_FC);
  localparam logic [7:0] REJ_ONE_LONG_CYC  = 8'(REJ_ONE_LONG_FC * PCLK_PER_FC);
  localparam logic [7:0] REJ_ONE_SHORT_CYC = 8'(REJ_ONE_SHORT_FC * PCLK_PER_FC);
  localparam logic [7:0] REJ_MID_CYC       = 8'(REJ_MID_FC * PCLK_PER_FC);

  // Cycles until the three-stage synchroniser holds real pin levels.
  localparam logic [1:0] STARTUP_CYC = 2'h3;

  typedef enum logic [1:0] {
    TRIG_RISE = 2'b00,
    TRIG_FALL = 2'b01,
    TRIG_BOTH = 2'b10,
    TRIG_HIGH = 2'b11
  } trig_e;

  typedef struct packed {
    logic  filter_sel;
    logic  pin_function;
    trig_e trig_four;
    logic  es_three;
    logic  es_two;
    logic  es_one;
    logic  spare;
  } ctrl_s;

endpackage : ext_irq_pkg

// File: irq_cond_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module irq_cond_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  ext_irq_pin,
  input wire logic        irq
);
  logic [5:0] prev_pin;
  logic [7:0] quiet;
  logic       mapped;
  assign mapped = paddr inside {ext_irq_pkg::CTRL_ADDR, ext_irq_pkg::STATUS_ADDR,
    ext_irq_pkg::MASK_ADDR, ext_irq_pkg::MASTER_ADDR, ext_irq_pkg::LEVEL_ADDR};
  // A new request needs a recent cause: a pin change or a register write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_pin <= 6'h3f;
      quiet    <= 8'h00;
    end else begin
      prev_pin <= ext_irq_pin;
      if (ext_irq_pin != prev_pin || (pready && pwrite)) begin
        quiet <= 8'h00;
      end else if (quiet != 8'hff) begin
        quiet <= quiet + 8'h01;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address map");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  chk_irq_reset: assert property (!$past(presetn) |-> !irq)
    else $error("request right after reset");
  chk_irq_cause: assert property ($rose(irq) |-> quiet < 8'd200)
    else $error("request without a recent cause");
  chk_irq_drop: assert property ($fell(irq) |-> $past(pready && pwrite)
    || $past(pready && pwrite, 2))
    else $error("request dropped without a register write");
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule : irq_cond_checker
bind external_interrupt_input_conditioner irq_cond_checker i_chk (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .irq(irq));
`default_nettype wire

// File: irq_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module irq_pin_source (
  input  wire logic       clk,
  output var  logic [5:0] pins
);
  // Sources drive push-pull and idle high, so a pin never floats.
  initial pins = 6'h3f;
  task automatic drive(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
  endtask : drive
  task automatic pulse(input int i, input int n);
    drive(i, 1'h0);
    repeat (n) @(posedge clk);
    pins[i] <= 1'h1;
  endtask : pulse
endmodule : irq_pin_source
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  wire logic [5:0] pins;
  int          errors = 0;
  int          samples_checked = 0;
  logic [31:0] q;
  logic        e;
  // Each entry: control value, pin, low pulse length, expected latch.
  // Short pulses sit just under the reject time, long ones at the accept time (the pin function 0 entry uses 10),
  // so neither check leans on behaviour inside the undefined band between them.
  logic [31:0] tbl [13] = '{32'hb6000a00, 32'hf6000100, 32'hf6000601, 32'hf6050100,
    32'hf6050601, 32'hf6010e00, 32'hf6013001, 32'h76013e00, 32'h7601c001,
    32'hf6020600, 32'hf6021801, 32'hf6030600, 32'hf6031801};
  always #2 pclk = ~pclk;
  external_interrupt_input_conditioner i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h1),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(pins), .irq(irq));
  irq_pin_source i_src (.clk(pclk), .pins(pins));
  task automatic report_and_stop();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic try_pin(input int i, input int n, input logic x);
    wr(ext_irq_pkg::STATUS_ADDR, 32'h3f);
    i_src.pulse(i, n);
    repeat (40) @(posedge pclk);
    rd(ext_irq_pkg::STATUS_ADDR, 32'(x) << i);
    chk(32'(irq), 32'(x));
  endtask : try_pin
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    rd(ext_irq_pkg::CTRL_ADDR, 32'h0);
    rd(ext_irq_pkg::MASK_ADDR, 32'h0);
    rd(12'h200, 32'h0);
    chk(32'(e), 32'h1);
    wr(ext_irq_pkg::MASK_ADDR, 32'h3f);
    foreach (tbl[k]) begin
      wr(ext_irq_pkg::MASTER_ADDR, 32'h0);
      wr(ext_irq_pkg::CTRL_ADDR, {24'h0, tbl[k][31:24]});
      rd(ext_irq_pkg::CTRL_ADDR, {24'h0, tbl[k][31:24]});
      repeat (64) @(posedge pclk);
      wr(ext_irq_pkg::MASTER_ADDR, 32'h1);
      try_pin(tbl[k][23:16], tbl[k][15:8], tbl[k][0]);
    end
    i_src.drive(4, 1'h0);
    for (int m = 0; m < 4; m++) begin
      wr(ext_irq_pkg::CTRL_ADDR, 32'hc6 | (m << 4));
      repeat (64) @(posedge pclk);
      wr(ext_irq_pkg::STATUS_ADDR, 32'h3f);
      i_src.drive(4, 1'h1);
      repeat (40) @(posedge pclk);
      rd(ext_irq_pkg::STATUS_ADDR, (m != 1) ? 32'h10 : 32'h0);
      wr(ext_irq_pkg::STATUS_ADDR, 32'h3f);
      i_src.drive(4, 1'h0);
      repeat (40) @(posedge pclk);
      rd(ext_irq_pkg::STATUS_ADDR, (m != 0) ? 32'h10 : 32'h0);
    end
    chk(32'(irq), 32'h1);
    wr(ext_irq_pkg::MASK_ADDR, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rd(ext_irq_pkg::LEVEL_ADDR, 32'h2f);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
